/* hw/tocp_timer.sv */
// Two 16-bit timer channels with output compare on four pins each and PWM on three (B, C, D).
// Assumes all inputs synchronous to clk; pins are resolved outside from out/oe.
//
// Function
// R1: Counter-clear select field picks which compare match zeroes the counter.
// R2: Clearing on FFFFH wraps to 0000H like overflow and sets the overflow flag.
// R3: Clear select 001B zeroes the counter on register A match.
// R4: Pin A/B action 011B toggles on match, 010B drives high.
// R5: Pin C/D action 1001B drives low; 1000B disables output and D-to-B routing.
// R6: Initial-output bit sets each pin level from count start to first match.
// R7: A pin drives only while its output-enable bit is 0.
// R8: Stop select 1 keeps counting through register A matches.
// R9: Buffer bits at 0 leave registers C and D as independent compares.
// R10: Matches on A-D and overflow set sticky flags and raise a request.
// R11: Software clears a flag by writing 0; hardware never clears it.
// R12: C/D action bit 3 at 0 routes C matches to pin A, D to pin B.
// R13: Software keeps buffers off and C differs from A, D from B when routing.
// R14: Up to three PWM pins per channel, six with both channels synchronised.
// R15: Register A sets the period for all PWM pins; B, C, D individually PWM.
// R16: Count up only; period m+1, active m-n, inactive n+1 ticks.
// R17: Count source: high-speed tick, clk, clk/2, /4, /8, /32, or external edge.
// R18: Writing 1 to the start bit starts the channel.
// R19: Stop select 1: writing 0 stops the count and PWM pins hold their level.
// R20: Stop select 0: counting stops at A match, pins keep post-match level.
// R21: Per-pin PWM active-level bit: 1 active high, 0 active low.
// R22: PWM compare above period never matches, giving 0% duty.
// R23: Compares checked each tick, one action per pin, period match wins.
// R24: Counter reads return the live count; writes load it immediately.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module tocp_timer
(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [tocp_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output wire logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output wire logic                          s_axi_wready,
  output wire logic [1:0]                    s_axi_bresp,
  output wire logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [tocp_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output wire logic                          s_axi_arready,
  output wire logic [31:0]                   s_axi_rdata,
  output wire logic [1:0]                    s_axi_rresp,
  output wire logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          hocoTick,
  input  wire logic                          externalCountClock,
  output wire logic [7:0]                    timerPinOut,
  output wire logic [7:0]                    timerPinOe,
  output wire logic [1:0]                    matchIrq
);
  import tocp_pkg::*;

  tocp_state_t state_ff;
  tocp_state_t nxt_state;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // Returns {hit, data}; unmapped addresses miss and read as zero
  function automatic logic [32:0] regRead(input tocp_state_t s, input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    logic        ch;
    r  = 33'h0_0000_0000;
    ch = (a[7:6] == BANK_CH1);
    if (a[7:6] == BANK_GLOBAL)
    begin
      case (a)
        OFF_START:    r = {1'b1, 24'h00_0000, 2'h0, s.stopSel, 2'h0, s.start};
        OFF_MODE:     r = {1'b1, 24'h00_0000, s.mode};
        OFF_PWM_EN:   r = {1'b1, 24'h00_0000, 1'b0, s.pwmEn[1], 1'b0, s.pwmEn[0]};
        OFF_OUT_EN:   r = {1'b1, 24'h00_0000, s.outEn};
        OFF_INIT_OUT: r = {1'b1, 24'h00_0000, s.initOut};
        default:      r = 33'h0_0000_0000;
      endcase
    end
    else if (a[1:0] == 2'h0 && (a[7:6] == BANK_CH0 || ch))
    begin
      case (a[5:2])
        IDX_CTRL: r = {1'b1, 24'h00_0000, s.ctrl[ch]};
        IDX_IOAB: r = {1'b1, 24'h00_0000, s.ioab[ch]};
        IDX_IOCD: r = {1'b1, 24'h00_0000, s.iocd[ch]};
        IDX_STAT: r = {1'b1, 27'h000_0000, s.stat[ch]};
        IDX_POL:  r = {1'b1, 29'h0000_0000, s.pol[ch]};
        IDX_CNT:  r = {1'b1, 16'h0000, s.cnt[ch]};                         // R24
        default:
        begin
          if (a[5:2] >= IDX_GRA && a[5:2] <= IDX_GRD)
          begin
            r = {1'b1, 16'h0000, s.gr[ch][2'(a[5:2] - IDX_GRA)]};
          end
        end
      endcase
    end
    return r;
  endfunction : regRead

  // Output action of a compare match on a pin level
  function automatic logic applyAct(input logic lvl, input logic [2:0] act);
    logic res;
    case (act)
      ACT_LOW:    res = 1'b0;
      ACT_HIGH:   res = 1'b1;                                              // R4
      ACT_TOGGLE: res = ~lvl;                                              // R4
      default:    res = lvl;                                               // R5
    endcase
    return res;
  endfunction : applyAct

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [32:0]      rdHit;
    logic [31:0]      wrVal;
    logic             wrDo;
    logic             wrCh;
    logic [1:0]       wrCnt;
    logic [1:0]       tick;
    logic [1:0]       clrEv;
    logic [3:0]       m;
    logic             ovf;
    logic             extEdge;
    logic [4:0]       setFlags;
    logic [2:0]       srcSel;
    logic [2:0]       clrSel;
    logic             pwmPin;
    logic [2:0]       actC;
    logic [2:0]       actD;
    rdHit    = 33'h0_0000_0000;
    wrVal    = 32'h0000_0000;
    wrCh     = (state_ff.awAddr[7:6] == BANK_CH1);
    wrCnt    = 2'b00;
    tick     = 2'b00;
    clrEv    = 2'b00;
    m        = 4'h0;
    ovf      = 1'b0;
    setFlags = 5'h00;
    srcSel   = SRC_CLK;
    clrSel   = 3'h0;
    pwmPin   = 1'b0;
    actC     = 3'h0;
    actD     = 3'h0;
    extEdge  = 1'b0;
    wrDo     = state_ff.awHeld && state_ff.wHeld;
    nxt_state = state_ff;

    // AXI4-Lite channels
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_state.awHeld = 1'b1;
      nxt_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_state.wHeld = 1'b1;
      nxt_state.wData = s_axi_wdata;
      nxt_state.wStrb = s_axi_wstrb;
    end
    if (state_ff.bValid && s_axi_bready)
    begin
      nxt_state.bValid = 1'b0;
    end
    if (state_ff.rValid && s_axi_rready)
    begin
      nxt_state.rValid = 1'b0;
    end
    if (s_axi_arvalid && !state_ff.rValid)
    begin
      rdHit            = regRead(state_ff, s_axi_araddr);
      nxt_state.rValid = 1'b1;
      nxt_state.rData  = rdHit[31:0];
      nxt_state.rResp  = rdHit[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // Register writes, done once both address and data are held
    if (wrDo)
    begin
      rdHit            = regRead(state_ff, state_ff.awAddr);
      wrVal            = mergeBytes(rdHit[31:0], state_ff.wData, state_ff.wStrb);
      nxt_state.awHeld = 1'b0;
      nxt_state.wHeld  = 1'b0;
      nxt_state.bValid = 1'b1;
      nxt_state.bResp  = rdHit[32] ? RESP_OKAY : RESP_SLVERR;
      if (rdHit[32] && state_ff.awAddr[7:6] == BANK_GLOBAL)
      begin
        case (state_ff.awAddr)
          OFF_START:
          begin
            nxt_state.start   = wrVal[1:0];                                // R18 R19
            nxt_state.stopSel = wrVal[STOPSEL_LSB +: 2];
          end
          OFF_MODE:     nxt_state.mode    = wrVal[7:0];
          OFF_PWM_EN:
          begin
            nxt_state.pwmEn[0] = wrVal[2:0];
            nxt_state.pwmEn[1] = wrVal[PWM1_LSB +: 3];
          end
          OFF_OUT_EN:   nxt_state.outEn   = wrVal[7:0];
          OFF_INIT_OUT: nxt_state.initOut = wrVal[7:0];
          default:      nxt_state.mode    = state_ff.mode;
        endcase
      end
      else if (rdHit[32])
      begin
        case (state_ff.awAddr[5:2])
          IDX_CTRL: nxt_state.ctrl[wrCh] = wrVal[7:0];
          IDX_IOAB: nxt_state.ioab[wrCh] = wrVal[7:0];
          IDX_IOCD: nxt_state.iocd[wrCh] = wrVal[7:0];
          IDX_STAT:
          begin
            // Only a written 0 clears; a 1 leaves the flag alone
            if (state_ff.wStrb[0])
            begin
              nxt_state.stat[wrCh] = state_ff.stat[wrCh] & state_ff.wData[4:0]; // R11
            end
          end
          IDX_POL:  nxt_state.pol[wrCh] = wrVal[2:0];
          IDX_CNT:
          begin
            // With the channels synchronised a count write loads both counters
            if (state_ff.mode[SYNC_BIT])
            begin
              nxt_state.cnt = {wrVal[15:0], wrVal[15:0]};                  // R24
              wrCnt         = 2'b11;
            end
            else
            begin
              nxt_state.cnt[wrCh] = wrVal[15:0];                           // R24
              wrCnt[wrCh]         = 1'b1;
            end
          end
          default:  nxt_state.gr[wrCh][2'(state_ff.awAddr[5:2] - IDX_GRA)] = wrVal[15:0];
        endcase
      end
    end

    // Count sources
    nxt_state.presc   = state_ff.presc + 5'h01;
    nxt_state.extPrev = externalCountClock;
    for (int k = 0; k < 2; k++)
    begin
      srcSel = state_ff.ctrl[k][SRC_LSB +: 3];
      case (state_ff.ctrl[k][EDGE_LSB +: 2])
        EDGE_FALL: extEdge = !externalCountClock && state_ff.extPrev;
        EDGE_BOTH: extEdge = externalCountClock != state_ff.extPrev;
        default:   extEdge = externalCountClock && !state_ff.extPrev;
      endcase
      case (srcSel)                                                        // R17
        SRC_CLK:   tick[k] = 1'b1;
        SRC_DIV2:  tick[k] = state_ff.presc[0];
        SRC_DIV4:  tick[k] = &state_ff.presc[1:0];
        SRC_DIV8:  tick[k] = &state_ff.presc[2:0];
        SRC_DIV32: tick[k] = &state_ff.presc;
        SRC_EXT:   tick[k] = extEdge;
        SRC_HOCO:  tick[k] = hocoTick;
        default:   tick[k] = 1'b0;
      endcase
    end
    tick[1] = state_ff.mode[SYNC_BIT] ? tick[0] : tick[1];                 // R14

    // Compare, clear, flags and pin actions per channel.
    // Buffer bits are stored only; C and D always act as plain compares.
    for (int k = 0; k < 2; k++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        m[j] = state_ff.cnt[k] == state_ff.gr[k][j];                       // R9 R23
      end
      ovf    = state_ff.cnt[k] == CNT_MAX;
      clrSel = state_ff.ctrl[k][CLR_LSB +: 3];
      case (clrSel)                                                        // R1
        CLR_A:    clrEv[k] = m[0];                                         // R3
        CLR_B:    clrEv[k] = m[1];
        CLR_C:    clrEv[k] = m[2];
        CLR_D:    clrEv[k] = m[3];
        CLR_SYNC: clrEv[k] = (k == 1) && state_ff.mode[SYNC_BIT] && clrEv[0];
        default:  clrEv[k] = 1'b0;
      endcase
      clrEv[k] = (|state_ff.pwmEn[k]) ? m[0] : clrEv[k];                   // R15 R16
      actC = state_ff.iocd[k][2:0];
      actD = state_ff.iocd[k][ACT_D_LSB +: 3];
      if (state_ff.start[k] && tick[k])
      begin
        setFlags = {ovf, m};                                               // R10 R2
        if (!wrCnt[k])
        begin
          nxt_state.cnt[k] = clrEv[k] ? 16'h0000 : state_ff.cnt[k] + 16'h0001; // R2 R16
        end
        nxt_state.stat[k] = nxt_state.stat[k] | setFlags;                  // R10
        if (!state_ff.stopSel[k] && m[0] && !(wrDo && state_ff.awAddr == OFF_START))
        begin
          nxt_state.start[k] = 1'b0;                                       // R20 R8
        end
        // Pin A: register A first, routed register C second
        if (m[0])
        begin
          nxt_state.level[k][0] = applyAct(state_ff.level[k][0], state_ff.ioab[k][2:0]); // R4
        end
        else if (m[2] && !state_ff.iocd[k][ROUTE_C_BIT])
        begin
          nxt_state.level[k][0] = applyAct(state_ff.level[k][0], actC);    // R12
        end
        // Pins B, C, D: PWM or compare output
        for (int j = 1; j < 4; j++)
        begin
          pwmPin = state_ff.pwmEn[k][j-1];
          if (pwmPin && m[0])
          begin
            nxt_state.level[k][j] = !state_ff.pol[k][j-1];                 // R23 R21
          end
          else if (pwmPin && m[j])
          begin
            nxt_state.level[k][j] = state_ff.pol[k][j-1];                  // R16 R21 R22
          end
          else if (!pwmPin && j == 1 && m[1])
          begin
            nxt_state.level[k][j] = applyAct(state_ff.level[k][j], state_ff.ioab[k][ACT_B_LSB +: 3]); // R4
          end
          else if (!pwmPin && j == 1 && m[3] && !state_ff.iocd[k][ROUTE_D_BIT])
          begin
            nxt_state.level[k][j] = applyAct(state_ff.level[k][j], actD);  // R12
          end
          else if (!pwmPin && j == 2 && m[2] && state_ff.iocd[k][ROUTE_C_BIT])
          begin
            nxt_state.level[k][j] = applyAct(state_ff.level[k][j], actC);  // R5
          end
          else if (!pwmPin && j == 3 && m[3] && state_ff.iocd[k][ROUTE_D_BIT])
          begin
            nxt_state.level[k][j] = applyAct(state_ff.level[k][j], actD);  // R5
          end
        end
      end
      // Stopped channels leave levels untouched, so pins hold their value
      if (!state_ff.start[k] && nxt_state.start[k])
      begin
        nxt_state.level[k] = state_ff.initOut[k*4 +: 4];                   // R6 R19
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff         <= '0;
      state_ff.outEn   <= RST_OUT_EN;
      state_ff.gr      <= {8{RST_GR}};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign s_axi_awready = !state_ff.awHeld && !state_ff.bValid;
  assign s_axi_wready  = !state_ff.wHeld && !state_ff.bValid;
  assign s_axi_bvalid  = state_ff.bValid;
  assign s_axi_bresp   = state_ff.bResp;
  assign s_axi_arready = !state_ff.rValid;
  assign s_axi_rvalid  = state_ff.rValid;
  assign s_axi_rdata   = state_ff.rData;
  assign s_axi_rresp   = state_ff.rResp;
  assign timerPinOut   = {state_ff.level[1], state_ff.level[0]};
  assign timerPinOe    = ~state_ff.outEn;                                  // R7
  assign matchIrq      = {|state_ff.stat[1], |state_ff.stat[0]};           // R10

endmodule : tocp_timer

/* hw/tocp_pkg.sv */
// Constants and state layout for the two-channel output compare / PWM timer.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package tocp_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 16;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_START    = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_PWM_EN   = 8'h08;
  localparam logic [7:0] OFF_OUT_EN   = 8'h0C;
  localparam logic [7:0] OFF_INIT_OUT = 8'h10;
  localparam logic [1:0] BANK_GLOBAL  = 2'h0;
  localparam logic [1:0] BANK_CH0     = 2'h1;
  localparam logic [1:0] BANK_CH1     = 2'h2;
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_IOAB     = 4'h1;
  localparam logic [3:0] IDX_IOCD     = 4'h2;
  localparam logic [3:0] IDX_STAT     = 4'h3;
  localparam logic [3:0] IDX_POL      = 4'h4;
  localparam logic [3:0] IDX_CNT      = 4'h5;
  localparam logic [3:0] IDX_GRA      = 4'h6;
  localparam logic [3:0] IDX_GRD      = 4'h9;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int STOPSEL_LSB = 4;
  localparam int SYNC_BIT    = 0;
  localparam int BUF_LSB     = 4;
  localparam int SRC_LSB     = 0;
  localparam int EDGE_LSB    = 3;
  localparam int CLR_LSB     = 5;
  localparam int ACT_B_LSB   = 4;
  localparam int ACT_D_LSB   = 4;
  localparam int ROUTE_C_BIT = 3;
  localparam int ROUTE_D_BIT = 7;
  localparam int OVF_BIT     = 4;
  localparam int PWM1_LSB    = 4;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ACT_LOW    = 3'h1;
  localparam logic [2:0] ACT_HIGH   = 3'h2;
  localparam logic [2:0] ACT_TOGGLE = 3'h3;
  localparam logic [2:0] CLR_A      = 3'h1;
  localparam logic [2:0] CLR_B      = 3'h2;
  localparam logic [2:0] CLR_SYNC   = 3'h3;
  localparam logic [2:0] CLR_C      = 3'h5;
  localparam logic [2:0] CLR_D      = 3'h6;
  localparam logic [2:0] SRC_CLK    = 3'h0;
  localparam logic [2:0] SRC_DIV2   = 3'h1;
  localparam logic [2:0] SRC_DIV4   = 3'h2;
  localparam logic [2:0] SRC_DIV8   = 3'h3;
  localparam logic [2:0] SRC_DIV32  = 3'h4;
  localparam logic [2:0] SRC_EXT    = 3'h5;
  localparam logic [2:0] SRC_HOCO   = 3'h6;
  localparam logic [1:0] EDGE_RISE  = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;
  localparam logic [1:0] EDGE_BOTH  = 2'h2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Reset values and count limit
  // ---------------------------------------------------------------------------
  localparam logic [7:0]       RST_OUT_EN = 8'hFF;
  localparam logic [CNT_W-1:0] RST_GR     = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;

  typedef struct packed {
    logic [1:0]                 start;
    logic [1:0]                 stopSel;
    logic [7:0]                 mode;
    logic [1:0][2:0]            pwmEn;
    logic [7:0]                 outEn;
    logic [7:0]                 initOut;
    logic [1:0][7:0]            ctrl;
    logic [1:0][7:0]            ioab;
    logic [1:0][7:0]            iocd;
    logic [1:0][4:0]            stat;
    logic [1:0][2:0]            pol;
    logic [1:0][CNT_W-1:0]      cnt;
    logic [1:0][3:0][CNT_W-1:0] gr;
    logic [1:0][3:0]            level;
    logic [4:0]                 presc;
    logic                       extPrev;
    logic                       awHeld;
    logic [ADDR_W-1:0]          awAddr;
    logic                       wHeld;
    logic [31:0]                wData;
    logic [3:0]                 wStrb;
    logic                       bValid;
    logic [1:0]                 bResp;
    logic                       rValid;
    logic [1:0]                 rResp;
    logic [31:0]                rData;
  } tocp_state_t;

endpackage : tocp_pkg

/* test/tocp_checker.sv */
// Bus and pin checker for the two-channel compare / PWM timer.
// Assumes it is bound onto tocp_timer and sees only its ports.
`timescale 1ns/10ps
module tocp_checker
(
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [tocp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [7:0]                  timerPinOe,
  input wire logic [1:0]                  matchIrq
);
  import tocp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] == 2'h3; endsequence
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rd_err; s_bad |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR; endproperty
  property p_wr_ans; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  // Enables move only as the result of a register write
  property p_oe_src; $changed(timerPinOe) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  // With no write under way a raised flag cannot fall
  property p_irq_keep;
    s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid
      |=> (matchIrq & $past(matchIrq)) == $past(matchIrq);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  a_w_block: assert property (p_w_block) else $error("write taken during response");
  a_r_block: assert property (p_r_block) else $error("read taken during response");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  a_oe_src: assert property (p_oe_src) else $error("pin enable moved alone");
  a_irq_keep: assert property (p_irq_keep) else $error("flag cleared by itself");
endmodule : tocp_checker
bind tocp_timer tocp_checker u_chk (.*);

/* test/tocp_load_model.sv */
// Load model: the level seen on each timer pin.
// Assumes one pin per bit of the timer's pin output bus.
`timescale 1ns/10ps
module tocp_load_model
(
  input  wire logic       clk,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  output wire logic [7:0] pinLevel
);
  logic [7:0] lastLevel_ff = 8'h00;
  // Undriven pins flip each cycle so a floating line never looks valid
  assign pinLevel = (pinOut & pinOe) | (~lastLevel_ff & ~pinOe);
  always @(posedge clk) lastLevel_ff <= pinLevel;
endmodule : tocp_load_model

/* test/timer_output_compare_pwm_test.sv */
// Self-checking bench for the two-channel compare / PWM timer.
// Assumes the load model and the checker are compiled first.
`timescale 1ns/10ps
module timer_output_compare_pwm_test;
  import tocp_pkg::*;
  logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, hoco = 0, ext = 0;
  logic awr, wrr, bv, arr, rv;
  logic [1:0] irq, brs;
  logic [7:0] awa = 0, ara = 0, pin, oe, out;
  logic [31:0] wd = 0, rd, n, hi, hc, hd, seed = 32'h0000_8442, expQ[$];
  int fails = 0, checksDone = 0, cyc = 0;
  localparam logic [15:0] SETA [9] = '{16'h5809, 16'h5C04, 16'h6006, 16'h4020, 16'h4423,
                                      16'h4889, 16'h1004, 16'h0C00, 16'h0001};
  localparam logic [15:0] SETC [6] = '{16'h4400, 16'h0807, 16'h5003, 16'h5807, 16'h6009, 16'h4021};
  always #20 clk = ~clk;
  tocp_timer u_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(brs),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rre), .hocoTick(hoco),
    .externalCountClock(ext), .timerPinOut(out), .timerPinOe(oe), .matchIrq(irq));
  tocp_load_model u_load (.clk(clk), .pinOut(out), .pinOe(oe), .pinLevel(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checksDone++;
    if (got !== want)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic final_report;
    if (fails == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // Ready follows valid by a cycle, so the response hold checks see a stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    do
    begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrr) wv <= 0;
    end
    while (awv || wv);
    while (!bv) @(posedge clk);
    bre <= 1;
    @(posedge clk);
    chk(brs, RESP_OKAY);
    bre <= 0;
  endtask : wr
  task automatic rdq(input logic [7:0] a, input logic [31:0] want);
    expQ.push_back(want);
    ara <= a;
    arv <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    rre <= 1;
    @(posedge clk);
    rre <= 0;
  endtask : rdq
  always @(posedge clk)
    if (rst_b && rv && rre) chk(rd, expQ.pop_front());
  // Random count-source inputs keep the unused sources moving; watchdog
  always @(posedge clk)
  begin
    seed <= lfsr(seed);
    hoco <= seed[0];
    ext <= seed[7];
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    rdq(8'h0C, 32'h0000_00FF);
    rdq(8'h58, 32'h0000_FFFF);
    rdq(8'hC0, 32'h0000_0000);
    foreach (SETA[i]) wr(SETA[i][15:8], {24'h0, SETA[i][7:0]});
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(pin[3:0], 32'h0000_0003);
    chk(oe[3:0], 32'h0000_000F);
    chk(irq[0], 32'h0000_0001);
    @(posedge clk);
    rdq(8'h54, 32'h0000_0000);
    rdq(8'h00, 32'h0000_0000);
    rdq(8'h4C, 32'h0000_0007);
    wr(8'h4C, 32'h0000_0000);
    rdq(8'h4C, 32'h0000_0000);
    chk(irq[0], 32'h0000_0000);
    wr(8'h88, 32'h0000_0003);
    wr(8'hA0, 32'h0000_0005);
    wr(8'h94, 32'h0000_1234);
    rdq(8'h94, 32'h0000_1234);
    wr(8'h94, 32'h0000_0000);
    wr(8'h00, 32'h0000_0022);
    repeat (30) @(posedge clk);
    wr(8'h00, 32'h0000_0020);
    @(negedge clk);
    chk(pin[4], 32'h0000_0001);
    chk(irq[1], 32'h0000_0001);
    @(posedge clk);
    rdq(8'h8C, 32'h0000_0004);
    n = seed % 6;
    foreach (SETC[i]) wr(SETC[i][15:8], {24'h0, SETC[i][7:0]});
    wr(8'h5C, n);
    wr(8'h00, 32'h0000_0011);
    repeat (32) @(posedge clk);
    hi = 0;
    hc = 0;
    hd = 0;
    repeat (64)
    begin
      @(negedge clk);
      hi += pin[1];
      hc += pin[2];
      hd += pin[3];
    end
    chk(hi, 8 * (7 - n));
    chk(hc, 32'h0000_0000);
    chk(hd, 32'h0000_0040);
    final_report();
  end
endmodule : timer_output_compare_pwm_test
